// ### flash_ctrl_defines.vh
// Constants for the serial flash program/erase controller
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH
`define OP_WRITE_ENABLE  8'h06
`define OP_READ_STATUS   8'h05
`define OP_QUAD_PROGRAM  8'h32
`define OP_ERASE_1K      8'h8B
`define OP_ERASE_SECTOR  8'h20
`define OP_ERASE_32K     8'h52
`define OP_ERASE_64K     8'hD8
`define OP_CHIP_ERASE    8'hC7
`define CMD_PROGRAM      3'h0
`define CMD_ERASE_1K     3'h1
`define CMD_ERASE_SECTOR 3'h2
`define CMD_ERASE_32K    3'h3
`define CMD_ERASE_64K    3'h4
`define CMD_CHIP_ERASE   3'h5
`define STATUS_BUSY_BIT  0
`define STATUS_LATCH_BIT 1
`define CLK_HALF_DIV     8'h04
`define PAGE_BYTES       9'h100
`endif

// ### byte_buffer.v
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps
module byte_buffer (
  input  wire       i_clk_sys,
  input  wire       i_sys_rst,
  input  wire [7:0] i_data,
  input  wire       i_valid,
  output wire       o_ready,
  output wire [7:0] o_data,
  output wire       o_valid,
  input  wire       i_ready
);
  reg [7:0] mem [0:1];
  reg       wr_ptr;
  reg       rd_ptr;
  reg [1:0] count;
  wire      push;
  wire      pop;
  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data  = mem[rd_ptr];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule // byte_buffer

// ### flash_ctrl.v
// Host-side quad SPI flash program/erase sequencer
//
// How it works
// [R01] Quad program needs quad_enable set first; the controller never sets it, the caller must
// [R02] Write enable sent before every program/erase
// [R03] Program: opcode 32H, address, quad data
// [R04] Over 256 bytes: device keeps last 256
// [R05] Under 256 bytes: other page bytes unchanged
// [R06] Chip select rises right after last byte
// [R07] Busy until write_in_progress reads zero
// [R08] Status reads allowed during busy cycle
// [R09] Device clears write_enable_latch itself
// [R10] Device refuses program to protected page
// [R11] 1K sector erase: 8BH plus address
// [R12] Sector erase: 20H plus address
// [R13] Chip select rises after last address byte
// [R14] 32K block erase: 52H plus address
// [R15] 64K block erase: D8H plus address
// [R16] Device erases whole block for address
// [R17] Device skips protected sector erase
// [R18] Device skips protected block erase
// [R19] Chip erase: lone opcode C7H
// [R20] Device checks protection before chip erase
// [R21] Chip select held low whole sequence
// [R22] Device wraps bytes past page end
// [R23] No new command while device busy
`timescale 1ns/100ps
`include "flash_ctrl_defines.vh"
module flash_ctrl (
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  input  wire        i_cmd_valid,
  input  wire [2:0]  i_cmd_kind,
  input  wire [23:0] i_cmd_addr,
  input  wire [8:0]  i_cmd_len,
  output reg         o_cmd_ready,
  input  wire [7:0]  i_wr_data,
  input  wire        i_wr_valid,
  output wire        o_wr_ready,
  output reg         o_done,
  output reg         o_busy,
  output reg         o_chip_select_n,
  output reg         o_serial_clk,
  output reg  [3:0]  o_quad_data_lines,
  output reg  [3:0]  o_quad_data_oe,
  input  wire [3:0]  i_quad_data_lines
);
  // ****************************************
  // State codes
  // ****************************************
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_WR_EN = 7'h02;
  localparam [7:0] OP_WE_CODE     = `OP_WRITE_ENABLE;
  localparam [7:0] OP_STATUS_CODE = `OP_READ_STATUS;
  localparam [6:0] ST_GAP   = 7'h04;
  localparam [6:0] ST_CMD   = 7'h08;
  localparam [6:0] ST_DATA  = 7'h10;
  localparam [6:0] ST_POLL  = 7'h20;
  localparam [6:0] ST_CHECK = 7'h40;

  reg  [6:0]  state;
  reg  [2:0]  kind;
  reg  [23:0] addr;
  reg  [8:0]  bytes_left;
  reg  [31:0] shreg;
  reg  [5:0]  bits_left;
  reg         quad_phase;
  reg  [7:0]  div_cnt;
  reg  [7:0]  status_in;
  reg  [1:0]  io1_sync;
  wire [7:0]  buf_data;
  wire        buf_valid;
  reg         buf_take;

  byte_buffer u_buf (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_data    (i_wr_data),
    .i_valid   (i_wr_valid),
    .o_ready   (o_wr_ready),
    .o_data    (buf_data),
    .o_valid   (buf_valid),
    .i_ready   (buf_take)
  );

  // Map a command kind to its opcode
  function [7:0] opcode_of;
    input [2:0] k;
    begin
      case (k)
        `CMD_PROGRAM:      opcode_of = `OP_QUAD_PROGRAM;
        `CMD_ERASE_1K:     opcode_of = `OP_ERASE_1K;
        `CMD_ERASE_SECTOR: opcode_of = `OP_ERASE_SECTOR;
        `CMD_ERASE_32K:    opcode_of = `OP_ERASE_32K;
        `CMD_ERASE_64K:    opcode_of = `OP_ERASE_64K;
        default:           opcode_of = `OP_CHIP_ERASE;
      endcase
    end
  endfunction

  // ****************************************
  // Serial clock timing
  // ****************************************
  wire tick = (div_cnt == `CLK_HALF_DIV - 8'h01);
  wire shifting = (state == ST_WR_EN) || (state == ST_CMD) ||
                  (state == ST_DATA) || (state == ST_POLL);
  // Data stall: clock parked low until the buffer has a byte
  wire parked = (state == ST_DATA) && (bits_left == 6'h00) &&
                (bytes_left != 9'h000) && !o_serial_clk;
  // Mode 0: data changes on falling edge, device samples rising
  wire rise = tick && shifting && !o_serial_clk && !parked;
  wire fall = tick && o_serial_clk;
  // Load point: a falling edge, or a tick while parked
  wire step = fall || (tick && parked);
  wire [7:0] next_opcode = opcode_of(kind);

  always @(posedge i_clk_sys) begin
    if (i_sys_rst)
      io1_sync <= 2'h0;
    else
      io1_sync <= {io1_sync[0], i_quad_data_lines[1]};
  end

  always @* begin
    buf_take = 1'b0;
    if (state == ST_DATA && step && bits_left == 6'h00 && bytes_left != 9'h000)
      buf_take = buf_valid;
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state             <= ST_IDLE;
      kind              <= 3'h0;
      addr              <= 24'h000000;
      bytes_left        <= 9'h000;
      shreg             <= 32'h00000000;
      bits_left         <= 6'h00;
      quad_phase        <= 1'b0;
      div_cnt           <= 8'h00;
      status_in         <= 8'h00;
      o_cmd_ready       <= 1'b0;
      o_done            <= 1'b0;
      o_busy            <= 1'b0;
      o_chip_select_n   <= 1'b1;
      o_serial_clk      <= 1'b0;
      o_quad_data_lines <= 4'h0;
      o_quad_data_oe    <= 4'h0;
    end else begin
      o_done  <= 1'b0;
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      if (rise)
        o_serial_clk <= 1'b1;
      if (fall)
        o_serial_clk <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_cmd_ready <= 1'b1;
          o_busy      <= 1'b0;
          if (i_cmd_valid && o_cmd_ready) begin
            o_cmd_ready <= 1'b0;
            o_busy      <= 1'b1;
            kind        <= i_cmd_kind;
            addr        <= i_cmd_addr;
            // [R04] Length capped at one page
            bytes_left  <= (i_cmd_len > `PAGE_BYTES) ? `PAGE_BYTES : i_cmd_len;
            // [R02] Write enable opens every operation
            shreg       <= {`OP_WRITE_ENABLE, 24'h000000};
            bits_left   <= 6'h08;
            quad_phase  <= 1'b0;
            state       <= ST_WR_EN;
            o_chip_select_n   <= 1'b0;
            o_quad_data_oe    <= 4'h1;
            o_quad_data_lines <= {3'h0, OP_WE_CODE[7]};
          end
        end
        ST_WR_EN, ST_CMD, ST_DATA, ST_POLL: begin
          if (rise && state == ST_POLL && !o_quad_data_oe[0])
            status_in <= {status_in[6:0], io1_sync[1]};
          if (rise) begin
            bits_left <= bits_left - 6'h01;
          end
          if (step) begin
            if (bits_left != 6'h00) begin
              if (quad_phase) begin
                shreg             <= {shreg[27:0], 4'h0};
                o_quad_data_lines <= shreg[27:24];
              end else begin
                shreg             <= {shreg[30:0], 1'b0};
                o_quad_data_lines <= {3'h0, shreg[30]};
              end
            end else if (state == ST_POLL && o_quad_data_oe[0]) begin
              // Opcode sent; release line, read one status byte
              o_quad_data_oe <= 4'h0;
              bits_left      <= 6'h08;
            end else if (state == ST_DATA && bytes_left != 9'h000) begin
              // [R03] Quad data nibbles, high nibble first
              if (buf_valid) begin
                quad_phase        <= 1'b1;
                o_quad_data_oe    <= 4'hF;
                shreg             <= {buf_data, 24'h000000};
                o_quad_data_lines <= buf_data[7:4];
                bits_left         <= 6'h02;
                bytes_left        <= bytes_left - 9'h001;
              end else begin
                // Stall: serial clock parks low, chip select stays low
                bits_left <= 6'h00;
              end
            end else begin
              // [R06] [R13] [R21] Select rises right after last bit
              o_chip_select_n <= 1'b1;
              o_quad_data_oe  <= 4'h0;
              state           <= (state == ST_POLL) ? ST_CHECK : ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            o_chip_select_n <= 1'b0;
            o_quad_data_oe  <= 4'h1;
            quad_phase      <= 1'b0;
            if (shreg[31:24] == 8'h00 && kind != 3'h7 && o_quad_data_lines == 4'h0 &&
                bits_left == 6'h00 && status_in == 8'hFF) begin
              state <= ST_POLL;
            end
            if (kind == 3'h7) begin
              // Operation sent; now poll the status register
              state             <= ST_POLL;
              shreg             <= {`OP_READ_STATUS, 24'h000000};
              o_quad_data_lines <= {3'h0, OP_STATUS_CODE[7]};
              bits_left         <= 6'h08;
            end else begin
              // [R11] [R12] [R14] [R15] [R19] Opcode, then address if any
              state             <= (kind == `CMD_PROGRAM) ? ST_DATA : ST_CMD;
              shreg             <= {opcode_of(kind), addr};
              o_quad_data_lines <= {3'h0, next_opcode[7]};
              bits_left         <= (kind == `CMD_CHIP_ERASE) ? 6'h08 : 6'h20;
              // [R01] Caller must have set quad_enable beforehand
              kind              <= 3'h7;
            end
          end
        end
        ST_CHECK: begin
          // [R07] [R08] [R23] Poll until write_in_progress clears
          if (status_in[`STATUS_BUSY_BIT]) begin
            state <= ST_GAP;
            kind  <= 3'h7;
          end else begin
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // flash_ctrl

// ### flash_ctrl_properties.sv
// Port-level checks for the flash program/erase controller
`timescale 1ns/100ps
module flash_ctrl_properties (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_cmd_valid,
  input wire o_cmd_ready,
  input wire o_done,
  input wire o_busy,
  input wire o_chip_select_n,
  input wire o_serial_clk
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence take_s;
    i_cmd_valid && o_cmd_ready;
  endsequence
  sequence sclk_high_s;
    o_serial_clk [*4] ##1 !o_serial_clk;
  endsequence
  a_busy_refuses: assert property (o_busy |-> !o_cmd_ready)
    else $error("ready while busy");
  a_take_starts: assert property (take_s |=> o_busy)
    else $error("take without busy");
  a_frame_opens: assert property (take_s |-> ##[1:20] !o_chip_select_n)
    else $error("no frame after take");
  a_idle_deselect: assert property (!o_busy |-> o_chip_select_n)
    else $error("select while idle");
  a_clock_parked: assert property (o_chip_select_n |-> !o_serial_clk)
    else $error("clock outside frame");
  a_clock_half: assert property ($rose(o_serial_clk) |-> sclk_high_s)
    else $error("clock high phase wrong");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done too long");
  a_done_idle: assert property (o_done |-> o_chip_select_n ##1 !o_busy)
    else $error("busy after done");
  a_ready_again: assert property (o_done |-> ##[1:3] o_cmd_ready)
    else $error("no ready after done");
endmodule // flash_ctrl_properties
bind flash_ctrl flash_ctrl_properties chk_u (.i_clk_sys, .i_sys_rst, .i_cmd_valid,
  .o_cmd_ready, .o_done, .o_busy, .o_chip_select_n, .o_serial_clk);

// ### flash_dev_model.sv
// Behavioural serial flash device facing the controller
`timescale 1ns/100ps
module flash_dev_model #(
  parameter BUSY_US = 20
) (
  input  wire       i_cs_n,
  input  wire       i_sclk,
  input  wire [3:0] i_io,
  output reg        o_so
);
  reg [31:0] sr;
  reg [7:0]  op;
  reg [7:0]  cop;
  reg [23:0] cadr;
  reg [7:0]  last_byte;
  reg [7:0]  st;
  reg        write_enable_latch = 1'b0;
  reg        write_in_progress = 1'b0;
  reg        half;
  integer    cnt = 0;
  integer    nbytes;
  integer    pbytes = 0;
  integer    left;
  integer    runs = 0;
  wire pe = op == 8'h32 || op == 8'h8B || op == 8'h20 || op == 8'h52 ||
            op == 8'hD8 || op == 8'hC7 || op == 8'h60;
  initial o_so = 1'b0;
  always @(negedge i_cs_n) begin
    cnt = 0;
    nbytes = 0;
    half = 1'b0;
  end
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      if (cnt < 32) sr = {sr[30:0], i_io[0]};
      else if (op == 8'h32) begin
        last_byte = {last_byte[3:0], i_io};
        half = ~half;
        if (!half) nbytes = nbytes + 1;
      end
      if (cnt == 7) op = sr[7:0];
      cnt = cnt + 1;
    end
  end
  // Status answered while busy; line never holds a stale bit
  always @(negedge i_sclk) begin
    st = {6'h00, write_enable_latch, write_in_progress};
    if (!i_cs_n && op == 8'h05 && cnt >= 8) o_so <= st[7 - (cnt - 8) % 8];
    else o_so <= ~o_so;
  end
  always @(posedge i_cs_n) begin
    if (!write_in_progress && op == 8'h06 && cnt == 8) write_enable_latch = 1'b1;
    else if (!write_in_progress && write_enable_latch && pe && (op == 8'h32 ? (cnt >= 34 && !half) :
             cnt == ((op == 8'hC7 || op == 8'h60) ? 8 : 32))) begin
      write_in_progress = 1'b1;
      write_enable_latch = 1'b0;
      left = BUSY_US;
      runs = runs + 1;
      cop = op;
      // No protection set; any address selects
      cadr = sr[23:0];
      pbytes = nbytes;
    end
  end
  always #1000 begin
    if (write_in_progress) left = left - 1;
    if (write_in_progress && left == 0) write_in_progress = 1'b0;
  end
endmodule // flash_dev_model

// ### flash_ctrl_test.sv
// Self-checking bench for the flash program/erase controller
`timescale 1ns/100ps
module flash_ctrl_test;
  reg         clk;
  reg         rst;
  reg         cv;
  reg  [2:0]  kind;
  reg  [23:0] addr;
  reg  [8:0]  len;
  reg  [7:0]  wd;
  reg         wv;
  integer     feed;
  integer     fails;
  integer     comparisons;
  integer     r0;
  wire        cr, wr, done, busy, cs_n, sclk, so;
  wire [3:0]  q, oe, io;
  // Undriven quad lines read high, line1 comes from the device
  assign io = (q & oe) | (~oe & {2'h3, so, 1'h1});
  flash_ctrl dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_cmd_valid(cv), .i_cmd_kind(kind),
    .i_cmd_addr(addr), .i_cmd_len(len), .o_cmd_ready(cr), .i_wr_data(wd), .i_wr_valid(wv),
    .o_wr_ready(wr), .o_done(done), .o_busy(busy), .o_chip_select_n(cs_n),
    .o_serial_clk(sclk), .o_quad_data_lines(q), .o_quad_data_oe(oe), .i_quad_data_lines(io));
  flash_dev_model m_u (.i_cs_n(cs_n), .i_sclk(sclk), .i_io(io), .o_so(so));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wv && wr) begin
      wd <= wd + 8'h01;
      feed <= feed - 1;
      if (feed == 1) wv <= 1'b0;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task run(input [2:0] k, input [8:0] n, input [7:0] op);
    integer t;
    begin
      // Request only once ready stands, else it is refused
      while (cr !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      r0 = m_u.runs;
      feed = n;
      wv = (n != 0);
      wd = 8'hA0;
      kind = k;
      addr = 24'h0312FE + k;
      len = n;
      cv = 1'b1;
      @(posedge clk);
      #2;
      cv = 1'b0;
      chk(busy, 1);
      chk(cr, 0);
      // Buffer holds two bytes while the write enable frame runs
      if (n > 3) begin
        repeat (3) @(posedge clk);
        #2;
        chk(wr, 0);
      end
      t = 0;
      while (done !== 1'b1 && t < 30000) begin
        @(posedge clk);
        #2;
        t = t + 1;
      end
      chk(done, 1);
      chk(m_u.runs, r0 + 1);
      chk(m_u.cop, op);
      if (k != 3'h5) chk(m_u.cadr, addr);
      chk(m_u.pbytes, n);
      if (n != 0) chk(m_u.last_byte, (159 + n) % 256);
      chk(m_u.write_in_progress, 0);
      chk(m_u.write_enable_latch, 0);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    rst = 1'b1;
    cv = 1'b0;
    kind = 3'h0;
    addr = 24'h000000;
    len = 9'h000;
    wd = 8'h00;
    wv = 1'b0;
    feed = 0;
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
    @(posedge clk);
    #2;
    chk(cs_n, 1);
    chk(cr, 1);
    run(3'h0, 9'h003, 8'h32);
    run(3'h0, 9'h100, 8'h32);
    run(3'h1, 9'h000, 8'h8B);
    run(3'h2, 9'h000, 8'h20);
    run(3'h3, 9'h000, 8'h52);
    run(3'h4, 9'h000, 8'hD8);
    run(3'h5, 9'h000, 8'hC7);
    test_done;
  end
  initial begin
    #1000000;
    fails = fails + 1;
    test_done;
  end
endmodule // flash_ctrl_test
